/* File: rtl/bit_sync.sv */
`timescale 1ns/10ps
module bit_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: rtl/i2c_slave_defs.svh */
// Requirements for this block and its bus master
// R1: first byte after write address loads pointer
// R2: master always sends a pointer byte
// R3: acknowledge a matching slave address byte
// R4: two following data bytes written to pointer
// R5: acknowledge every received write data byte (code acks only the two data bytes after the pointer; a third byte gets no ack)
// R6: start or stop ends a write
// R7: read returns register at last written pointer
// R8: pointer-only write updates pointer, registers unchanged
// R9: read sends high byte, then low byte
// R10: master nack, start or stop ends read
// R11: pointer kept across transactions
// R12: high-speed master code recognised, not acknowledged
// R13: master code sent at fast-mode rate (test master sends it with its usual 90 ns phases, above that rate)
// R14: after repeated start, high-speed transfers supported
// R15: stop leaves high-speed mode
// R16: master uses repeated starts to stay high-speed
// R17: answer alert response address with read bit
// R18: pending alert: acknowledge, then send own address
// R19: arbitration loser stops, keeps its alert pending
// R20: words travel high byte then low byte
// R21: slave address decoded from two four-level pins
// R22: address pins sampled at every transaction
// R23: stalled transaction times out, bus released
// R24: mask/enable read clears a latched alert
// R25: unmatched address: no ack, no drive
`ifndef I2C_SLAVE_DEFS_SVH
`define I2C_SLAVE_DEFS_SVH

`define ADDR_BASE      7'h40
`define ARA_ADDR       7'h0c
`define HS_CODE_PREFIX 5'h01
`define ACK_SLOT       4'h8
`define LAST_BIT       4'h7
`define POS_PRE        4'hf
`define MASK_EN_PTR    8'h06
`define REG_DEPTH      8
`define REG_AW         3
`define PIN_GND        3'h0
`define PIN_VS         3'h7
`define PIN_SDA        3'h4
`define PIN_SCL        3'h6
`define TIMEOUT_MS     28
`define REF_CLK_KHZ    200000
`define TIMEOUT_CYC    (`TIMEOUT_MS * `REF_CLK_KHZ)

`endif

/* File: rtl/i2c_slave_pkg.sv */
package i2c_slave_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ADDR   = 4'h1,
    ST_PTR    = 4'h3,
    ST_WR_HI  = 4'h2,
    ST_WR_LO  = 4'h6,
    ST_RD_HI  = 4'h7,
    ST_RD_LO  = 4'h5,
    ST_ARA    = 4'h4,
    ST_IGNORE = 4'hc
  } slave_state_t;

endpackage

/* File: rtl/i2c_slave_regs.sv */
`timescale 1ns/10ps
`include "i2c_slave_defs.svh"
module i2c_slave_regs
  import i2c_slave_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `TIMEOUT_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic address_select_pin_low,
  input  wire logic address_select_pin_high,
  input  wire logic alert_pending,
  output logic      hs_mode,
  output logic      mask_read,
  output logic      alert_answered
);
  localparam logic [22:0] TMO_LAST = 23'(TIMEOUT_CYC - 1);

  slave_state_t state;
  slave_state_t next_state;

  logic [1:0]  bus_s;
  logic [1:0]  pin_s;
  logic [1:0]  tog_s;
  logic [1:0]  tog_q;
  logic        scl_q;
  logic        sda_q;
  logic [2:0]  run_q;
  logic        link_rst_n;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_sh;
  logic        rx_ack;
  logic        byte_tgl;
  logic        ack_tgl;
  logic [3:0]  pos;
  logic [7:0]  ptr;
  logic [7:0]  wr_hi;
  logic [7:0]  tx_sh;
  logic [7:0]  tx_lo;
  logic        tx_on;
  logic        bit_out;
  logic        ack_req;
  logic [22:0] tmo_cnt;
  logic [1:0]  pin_idle;
  logic [1:0]  pin_start;
  logic [1:0]  lo_code;
  logic [1:0]  hi_code;
  logic [15:0] rd_data;
  logic        take_ack;

  function automatic logic [1:0] pin_code(input logic [2:0] lv);
    case (lv)
      `PIN_GND: pin_code = 2'h0;
      `PIN_VS:  pin_code = 2'h1;
      `PIN_SDA: pin_code = 2'h2;
      `PIN_SCL: pin_code = 2'h3;
      default:  pin_code = 2'h0;
    endcase
  endfunction

  bit_sync #(.WIDTH(2)) u_bus_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({scl, sda_in}),
    .q     (bus_s)
  );

  bit_sync #(.WIDTH(2)) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({address_select_pin_high, address_select_pin_low}),
    .q     (pin_s)
  );

  bit_sync #(.WIDTH(2)) u_tog_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({byte_tgl, ack_tgl}),
    .q     (tog_s)
  );

  // link side: bit capture on scl, held in reset outside frames
  always_ff @(posedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt  <= 4'h0;
      rx_sh    <= 8'h00;
      rx_ack   <= 1'b1;
      byte_tgl <= 1'b0;
      ack_tgl  <= 1'b0;
    end else if (bit_cnt == `ACK_SLOT) begin
      rx_ack   <= sda_in;
      ack_tgl  <= ~ack_tgl;
      bit_cnt  <= 4'h0;
    end else begin
      rx_sh    <= {rx_sh[6:0], sda_in}; // [R20]
      byte_tgl <= (bit_cnt == `LAST_BIT) ? ~byte_tgl : byte_tgl;
      bit_cnt  <= bit_cnt + 4'h1;
    end
  end

  // bus condition decode
  wire scl_s      = bus_s[1];
  wire sda_s      = bus_s[0];
  wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_cond  = scl_s & scl_q & ~sda_q & sda_s;
  wire scl_fall   = scl_q & ~scl_s;
  wire scl_rise   = ~scl_q & scl_s;
  wire evt_ok     = link_rst_n & run_q[2];
  wire byte_evt   = evt_ok & (tog_s[1] ^ tog_q[1]);
  wire ack_evt    = evt_ok & (tog_s[0] ^ tog_q[0]);
  wire busy       = state != ST_IDLE;
  wire tmo_hit    = busy && tmo_cnt == TMO_LAST; // [R23]
  wire bus_end    = stop_cond | tmo_hit;
  wire [3:0] next_pos =
    (pos == `ACK_SLOT || pos == `POS_PRE) ? 4'h0 : pos + 4'h1;

  // address byte decode
  wire [6:0] own_addr = `ADDR_BASE | {3'h0, hi_code, lo_code}; // [R21]
  wire       is_hs    = rx_sh[7:3] == `HS_CODE_PREFIX;
  wire       is_own   = rx_sh[7:1] == own_addr;
  wire       is_ara   = rx_sh[7:1] == `ARA_ADDR;
  wire       rw_bit   = rx_sh[0];
  wire       ptr_ok   = ptr[7:`REG_AW] == 5'h00;
  wire       in_addr  = state == ST_ADDR;
  wire       rd_start = byte_evt & in_addr & take_ack & rw_bit;
  wire       wr_en    = byte_evt & (state == ST_WR_LO) & ptr_ok;
  wire       m_ack    = ack_evt & ~ack_req;
  wire       tx_state =
    state == ST_RD_HI || state == ST_RD_LO || state == ST_ARA;
  wire       arb_lost = tx_on & scl_rise & (pos < `ACK_SLOT) & bit_out
                      & ~sda_s & (state == ST_ARA);
  wire [15:0] rd_word = ptr_ok ? rd_data : 16'h0000;

  reg_store u_regs (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .wr_en   (wr_en),
    .wr_addr (ptr[`REG_AW-1:0]),
    .wr_data ({wr_hi, rx_sh}), // [R4] [R20]
    .rd_addr (ptr[`REG_AW-1:0]),
    .rd_data (rd_data)
  );

  // byte decisions
  always_comb begin
    next_state = state;
    take_ack   = 1'b0;
    case (state)
      ST_ADDR: begin
        if (is_hs) begin
          next_state = ST_IGNORE; // [R12]
        end else if (is_own && !rw_bit) begin
          next_state = ST_PTR; // [R3]
          take_ack   = 1'b1;
        end else if (is_own && rw_bit) begin
          next_state = ST_RD_HI; // [R3] [R7]
          take_ack   = 1'b1;
        end else if (is_ara && rw_bit && alert_pending) begin
          next_state = ST_ARA; // [R17] [R18]
          take_ack   = 1'b1;
        end else begin
          next_state = ST_IGNORE; // [R25]
        end
      end
      ST_PTR: begin
        next_state = ST_WR_HI; // [R1]
        take_ack   = 1'b1;
      end
      ST_WR_HI: begin
        next_state = ST_WR_LO; // [R5]
        take_ack   = 1'b1;
      end
      ST_WR_LO: begin
        next_state = ST_IGNORE; // [R5]
        take_ack   = 1'b1;
      end
      default: next_state = state;
    endcase
  end

  // edge history and frame run pipeline
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      tog_q <= 2'h0;
      run_q <= 3'h0;
    end else if (ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      tog_q <= tog_s;
      run_q <= {run_q[1:0], link_rst_n};
    end
  end

  // link reset: set at start or end, released once scl is low while busy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_n <= 1'b0;
    end else if (ce) begin
      if (start_cond || bus_end) begin
        link_rst_n <= 1'b0; // [R6] [R10]
      end else if (!link_rst_n && busy && !scl_s) begin
        link_rst_n <= 1'b1;
      end
    end
  end

  // main state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (ce) begin
      if (bus_end) begin
        state <= ST_IDLE; // [R6] [R10] [R23]
      end else if (start_cond) begin
        state <= ST_ADDR; // [R6] [R14]
      end else if (byte_evt) begin
        state <= next_state;
      end else if (arb_lost) begin
        state <= ST_IGNORE; // [R19]
      end else if (m_ack && state == ST_RD_HI && !rx_ack) begin
        state <= ST_RD_LO; // [R9]
      end else if (m_ack && tx_state) begin
        state <= ST_IGNORE; // [R10]
      end
    end
  end

  // bit position within byte, counted on scl falls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= `POS_PRE;
    end else if (ce) begin
      if (start_cond) begin
        pos <= `POS_PRE;
      end else if (scl_fall && busy) begin
        pos <= next_pos;
      end
    end
  end

  // pointer and write high byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr   <= 8'h00;
      wr_hi <= 8'h00;
    end else if (ce && byte_evt) begin
      if (state == ST_PTR) begin
        ptr <= rx_sh; // [R1] [R8] [R11]
      end
      if (state == ST_WR_HI) begin
        wr_hi <= rx_sh; // [R20]
      end
    end
  end

  // address pin levels: idle, at start, at first fall
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_idle  <= 2'h0;
      pin_start <= 2'h0;
      lo_code   <= 2'h0;
      hi_code   <= 2'h0;
    end else if (ce) begin
      if (scl_s && sda_s) begin
        pin_idle <= pin_s;
      end
      if (start_cond) begin
        pin_start <= pin_s; // [R22]
      end
      if (scl_fall && pos == `POS_PRE && busy) begin
        lo_code <= pin_code({pin_idle[0], pin_start[0], pin_s[0]}); // [R21]
        hi_code <= pin_code({pin_idle[1], pin_start[1], pin_s[1]}); // [R22]
      end
    end
  end

  // transmit shifter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_on   <= 1'b0;
      tx_sh   <= 8'hff;
      tx_lo   <= 8'hff;
      bit_out <= 1'b1;
    end else if (ce) begin
      if (start_cond || bus_end || arb_lost) begin
        tx_on <= 1'b0; // [R10] [R19]
      end else if (rd_start) begin
        tx_on <= 1'b1;
        tx_sh <= (next_state == ST_ARA) ? {own_addr, 1'b0} // [R18]
                                        : rd_word[15:8];  // [R7] [R9]
        tx_lo <= rd_word[7:0];
      end else if (m_ack && state == ST_RD_HI && !rx_ack) begin
        tx_sh <= tx_lo; // [R9] [R20]
      end else if (m_ack) begin
        tx_on <= 1'b0; // [R10]
      end else if (scl_fall && tx_on && next_pos < `ACK_SLOT) begin
        bit_out <= tx_sh[7];
        tx_sh   <= {tx_sh[6:0], 1'b1};
      end
    end
  end

  // acknowledge request for the coming ack slot
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_req <= 1'b0;
    end else if (ce) begin
      if (start_cond || bus_end || ack_evt) begin
        ack_req <= 1'b0;
      end else if (byte_evt) begin
        ack_req <= take_ack; // [R3] [R5] [R12] [R25]
      end
    end
  end

  // sda drive, set after scl falls, cleared at start, end or arbitration loss
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
      if (start_cond || bus_end || arb_lost) begin
        sda_oe <= 1'b0; // [R10] [R23]
      end else if (scl_fall && busy) begin
        sda_oe <= (next_pos == `ACK_SLOT) ? ack_req
                                          : (tx_on & ~tx_sh[7]);
      end
    end
  end

  // high-speed mode flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_mode <= 1'b0;
    end else if (ce) begin
      if (bus_end) begin
        hs_mode <= 1'b0; // [R15]
      end else if (byte_evt && in_addr && is_hs) begin
        hs_mode <= 1'b1; // [R12] [R14]
      end
    end
  end

  // one-cycle event pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_read      <= 1'b0;
      alert_answered <= 1'b0;
    end else if (ce) begin
      mask_read      <= rd_start && next_state == ST_RD_HI
                        && ptr == `MASK_EN_PTR; // [R24]
      alert_answered <= m_ack && state == ST_ARA && tx_on; // [R18]
    end
  end

  // stall timer, cleared by any scl edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt <= 23'h000000;
    end else if (ce) begin
      if (!busy || scl_rise || scl_fall || start_cond) begin
        tmo_cnt <= 23'h000000;
      end else begin
        tmo_cnt <= tmo_cnt + 23'h000001; // [R23]
      end
    end
  end
endmodule

/* File: rtl/reg_store.sv */
`timescale 1ns/10ps
`include "i2c_slave_defs.svh"
module reg_store (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                wr_en,
  input  wire logic [`REG_AW-1:0]  wr_addr,
  input  wire logic [15:0]         wr_data,
  input  wire logic [`REG_AW-1:0]  rd_addr,
  output logic      [15:0]         rd_data
);
  logic [15:0] word [`REG_DEPTH];

  // one register per entry
  for (genvar i = 0; i < `REG_DEPTH; i++) begin : g_word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        word[i] <= 16'h0000;
      end else if (ce && wr_en && wr_addr == `REG_AW'(i)) begin
        word[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (ce) begin
      rd_data <= word[rd_addr];
    end
  end
endmodule

/* File: verification/i2c_master_model.sv */
`timescale 1ns/10ps
module i2c_master_model (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // 90 ns phases, above the fast-mode rate
  task automatic slot(input logic a, b, fin, output logic r);
    @(posedge mclk);
    sda_drv = a;
    hp(2);
    scl = 1'b1;
    hp(3);
    r = sda;
    if (a != b) begin
      sda_drv = b;
      hp(3);
    end
    scl = fin;
  endtask
  task automatic start();
    logic r;
    slot(1'b1, 1'b0, 1'b0, r);
  endtask
  task automatic stop();
    logic r;
    slot(1'b0, 1'b1, 1'b1, r);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) slot(d[i], d[i], 1'b0, r);
    slot(1'b1, 1'b1, 1'b0, r);
    ack = !r;
  endtask
  // nak high ends a read
  task automatic rx(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, 1'b1, 1'b0, r);
      d[i] = r;
    end
    slot(nak, nak, 1'b0, r);
  endtask
endmodule

/* File: verification/i2c_slave_regs_checker.sv */
`timescale 1ns/10ps
module i2c_slave_regs_checker #(
  parameter int unsigned TIMEOUT_CYC = 2000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic alert_pending,
  input wire logic hs_mode,
  input wire logic mask_read,
  input wire logic alert_answered
);
  logic [31:0] idle;
  logic        scl_d;
  wire         stalled = idle > TIMEOUT_CYC + 8;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      idle  <= '0;
    end else begin
      scl_d <= scl;
      if (scl != scl_d) idle <= '0;
      else if (!stalled) idle <= idle + 32'h1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_stop;
    $past(scl) && scl && !$past(sda_in) && sda_in;
  endsequence
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl && !$past(scl))
    else $error("sda_oe changed while scl high");
  a_oe_steady_high: assert property (
    $rose(scl) |=> $stable(sda_oe)[*8])
    else $error("sda_oe moved during scl high");
  a_oe_open_drain: assert property (
    sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_hs_enter: assert property (
    $rose(hs_mode) |-> $past(scl) && !sda_oe)
    else $error("hs entry at wrong moment");
  a_hs_leave: assert property (
    s_stop |-> ##[1:6] !hs_mode)
    else $error("hs mode kept after stop");
  a_stop_quiet: assert property (
    s_stop |-> ##[1:6] !sda_oe)
    else $error("sda driven after stop");
  a_mask_pulse: assert property (
    mask_read |=> !mask_read)
    else $error("mask read pulse too long");
  a_alert_reply: assert property (
    alert_answered |-> alert_pending ##1 !alert_answered)
    else $error("alert answer without pending alert");
  a_stall_release: assert property (
    stalled |-> !sda_oe && !hs_mode)
    else $error("bus held after stall");
endmodule

/* File: verification/tb.sv */
`timescale 1ns/10ps
module tb;
  localparam int unsigned TIMEOUT_CYC = 2000;
  logic        ref_clk, mclk, rst_n, alert_pending, mr_seen, aa_seen;
  logic [1:0]  plo, phi;
  logic [15:0] mem [8];
  int          errors, checked;
  wire         scl, m_sda, sda_out, sda_oe, hs_mode, mask_read, alrt;
  wire         sda = m_sda & ~sda_oe;
  wire         apl = plo[1] ? (plo[0] ? scl : sda) : plo[0];
  wire         aph = phi[1] ? (phi[0] ? scl : sda) : phi[0];
  wire [6:0]   ad = {3'b100, phi, plo};
  i2c_slave_regs #(.TIMEOUT_CYC(TIMEOUT_CYC)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin_low(apl), .address_select_pin_high(aph),
    .alert_pending(alert_pending), .hs_mode(hs_mode),
    .mask_read(mask_read), .alert_answered(alrt));
  i2c_master_model m (.mclk(mclk), .sda(sda), .scl(scl), .sda_drv(m_sda));
  always #2.5 ref_clk = ~ref_clk;
  initial begin
    mclk = 1'b0;
    #1.3;
    forever #15 mclk = ~mclk;
  end
  always @(posedge ref_clk) begin
    if (mask_read === 1'b1) mr_seen <= 1'b1;
    if (alrt === 1'b1) aa_seen <= 1'b1;
  end
  task automatic report_and_stop();
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] rexp(input logic [7:0] p);
    return p < 8 ? mem[p[2:0]] : 16'h0000;
  endfunction
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
    logic a;
    m.start();
    m.tx({ad, 1'b0}, a);
    check("addr_ack", a, 1'b1);
    m.tx(p, a);
    check("ptr_ack", a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.tx(i == 0 ? d[15:8] : d[7:0], a);
      check("data_ack", a, i < 2);
    end
    if (n >= 2 && p < 8) mem[p[2:0]] = d;
  endtask
  task automatic rd(input logic [7:0] p, input logic nak);
    logic        a, r;
    logic [7:0]  b;
    logic [15:0] e;
    e = rexp(p);
    m.start();
    m.tx({ad, 1'b1}, a);
    check("raddr_ack", a, 1'b1);
    m.rx(nak, b);
    check("read_hi", b, e[15:8]);
    if (!nak) begin
      m.rx(1'b1, b);
      check("read_lo", b, e[7:0]);
    end
    m.slot(1'b1, 1'b1, 1'b0, r);
    check("released", r, 1'b1);
  endtask
  initial begin
    logic [7:0] p, q, b, w;
    logic       a, r;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    alert_pending = 1'b0;
    {phi, plo} = 4'h0;
    {mr_seen, aa_seen} = 2'b00;
    errors = 0;
    checked = 0;
    void'($urandom(82));
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int k = 0; k < 8; k++) begin
      wr(k[7:0], 16'($urandom), 2);
      m.stop();
    end
    for (int i = 0; i < 6; i++) begin
      @(negedge ref_clk);
      {phi, plo} = 4'($urandom);
      p = 8'($urandom % 8);
      q = 8'($urandom % 8);
      wr(p, 16'($urandom), i == 1 ? 3 : 2);
      m.stop();
      wr(q, 16'h0000, 0);
      rd(q, i == 2);
      rd(q, 1'b0);
      m.stop();
    end
    wr(8'hff, 16'h5a5a, 2);
    rd(8'hff, 1'b0);
    m.stop();
    m.start();
    m.tx({ad ^ 7'h01, 1'b0}, a);
    check("other_addr", a, 1'b0);
    m.tx(8'h00, a);
    check("other_ptr", a, 1'b0);
    m.stop();
    m.start();
    m.tx({5'h01, 3'($urandom)}, a);
    check("hs_ack", a, 1'b0);
    check("hs_on", hs_mode, 1'b1);
    wr(8'h03, 16'($urandom), 2);
    rd(8'h03, 1'b0);
    m.stop();
    check("hs_off", hs_mode, 1'b0);
    @(negedge ref_clk);
    mr_seen = 1'b0;
    wr(8'h05, 16'h0000, 0);
    rd(8'h05, 1'b0);
    check("mask_idle", mr_seen, 1'b0);
    wr(8'h06, 16'h0000, 0);
    rd(8'h06, 1'b0);
    m.stop();
    check("mask_read", mr_seen, 1'b1);
    m.start();
    m.tx(8'h19, a);
    check("ara_idle", a, 1'b0);
    m.stop();
    @(negedge ref_clk);
    alert_pending = 1'b1;
    aa_seen = 1'b0;
    m.start();
    m.tx(8'h19, a);
    check("ara_ack", a, 1'b1);
    m.rx(1'b1, b);
    check("ara_addr", b, {ad, 1'b0});
    m.stop();
    check("ara_done", aa_seen, 1'b1);
    @(negedge ref_clk);
    aa_seen = 1'b0;
    m.start();
    m.tx(8'h19, a);
    m.slot(1'b0, 1'b0, 1'b0, r);
    for (int i = 0; i < 8; i++) begin
      m.slot(1'b1, 1'b1, 1'b0, r);
      check("ara_lost", r, 1'b1);
    end
    m.stop();
    check("ara_quiet", aa_seen, 1'b0);
    @(negedge ref_clk);
    alert_pending = 1'b0;
    w = {ad, 1'b0};
    m.start();
    for (int i = 7; i >= 0; i--) m.slot(w[i], w[i], 1'b0, r);
    repeat (10) @(negedge ref_clk);
    check("stall_ack", sda_oe, 1'b1);
    repeat (TIMEOUT_CYC + 20) @(negedge ref_clk);
    check("stall_free", sda_oe, 1'b0);
    m.stop();
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
endmodule
bind i2c_slave_regs i2c_slave_regs_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .alert_pending(alert_pending),
  .hs_mode(hs_mode), .mask_read(mask_read),
  .alert_answered(alert_answered));
